/* File: hw/crf_pkg.sv */
// package of register map, field positions and reset values for the control register bank
package crf_pkg;
    // register byte offsets
    localparam logic [7:0] MAIN_OFS      = 8'h00;
    localparam logic [7:0] PBASE_OFS     = 8'h0C;
    localparam logic [7:0] EXT_OFS       = 8'h10;
    localparam logic [7:0] ALIAS_LO_OFS  = 8'h30;
    localparam logic [7:0] ALIAS_HI_OFS  = 8'h34;
    localparam logic [7:0] DSTAT_OFS     = 8'h38;
    localparam logic [7:0] DCTRL_OFS     = 8'h3C;
    localparam logic [7:0] FAULT_OFS     = 8'h40;
    // extension control fields
    localparam int V86_EXT_BIT   = 0;
    localparam int VIP_BIT       = 1;
    localparam int TS_RESTR_BIT  = 2;
    localparam int DBG_EXT_BIT   = 3;
    localparam int LPG_BIT       = 4;
    localparam int XPA_BIT       = 5;
    localparam int MCK_BIT       = 6;
    localparam int GLB_BIT       = 7;
    localparam int CTR_BIT       = 8;
    localparam int OS_SAVE_BIT   = 9;
    localparam int OS_SIMD_BIT   = 10;
    // main control fields
    localparam int PROT_EN_BIT   = 0;
    localparam int FE_BIT        = 5;
    localparam int WP_BIT        = 16;
    localparam int MA_BIT        = 18;
    localparam int NT_BIT        = 29;
    localparam int CO_BIT        = 30;
    localparam int PAGING_BIT    = 31;
    // page base fields
    localparam int PTH_BIT       = 3;
    localparam int PNC_BIT       = 4;
    // debug control type fields: bits TYPE_LSB + 4*n
    localparam int TYPE_LSB      = 16;
    localparam int NUM_BP        = 4;
    // writable masks
    localparam logic [31:0] EXT_MASK   = 32'h0000_07FF;
    localparam logic [31:0] DSTAT_MASK = 32'hFFFF_EFFF;
    localparam logic [31:0] DCTRL_MASK = 32'hFFFF_27FF;
    // reset values
    localparam logic [31:0] EXT_RST    = 32'h0000_0000;
    localparam logic [31:0] MAIN_RST   = 32'h0000_0000;
    localparam logic [31:0] PBASE_RST  = 32'h0000_0000;
    localparam logic [31:0] DSTAT_RST  = 32'h0000_0000;
    localparam logic [31:0] DCTRL_RST  = 32'h0000_0000;
    // access kinds presented by the core for breakpoint matching
    localparam logic [1:0] KIND_EXEC  = 2'h0;
    localparam logic [1:0] KIND_WRITE = 2'h1;
    localparam logic [1:0] KIND_IO    = 2'h2;
    localparam logic [1:0] KIND_READ  = 2'h3;
    localparam logic [1:0] CPL_KERNEL = 2'h0;
endpackage : crf_pkg

/* File: hw/crf_bank.sv */
// control register bank with ahb-lite slave and derived control outputs
// Contract
// (RULE1) software sets extension bit 10 only if it handles SIMD float exceptions
// (RULE2) extension bit 5 enables extended physical addresses, else 32-bit only
// (RULE3) global page enable keeps global TLB entries on task switch or base write
// (RULE4) extension bit 8 lets counter read run at every privilege level
// (RULE5) hardware reset clears the whole extension control register
// (RULE6) v86 extensions flag enables virtual interrupts in virtual-8086 mode
// (RULE7) protected virtual interrupts flag enables virtual interrupts in protected mode
// (RULE8) timestamp restrict allows timestamp read only at privilege level 0
// (RULE9) page size extension allows 4M pages normally, 2M under address extension
// (RULE10) machine check enable gates the machine-check exception
// (RULE11) numeric error flag selects native float error reporting
// (RULE12) write protect blocks supervisor writes to read-only user pages
// (RULE13) alignment check needs both alignment mask and alignment check flags
// (RULE14) not-write-through set suppresses invalidations and hitting write-throughs
// (RULE15) cache enabled while cache disable is clear
// (RULE16) unpaged cycles with paging on drive page base cache flags onto pins
// (RULE17) address extension acts only while paging is enabled
// (RULE18) descriptor load does locked update only if accessed bit clear
// (RULE19) debug status bit 12 ignores writes of one
// (RULE20) breakpoint type field decodes exec, write, io if extensions, read-write
// (RULE21) debug control bits 11, 12, 14, 15 read as zero
// (RULE22) alias registers map to debug status/control, or fault with extensions on
`timescale 1ns/1ps
module crf_bank (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // core state
    input  wire logic [1:0]  cpl,
    input  wire logic        v86_mode,
    input  wire logic        task_switch,
    input  wire logic        alignment_check,
    input  wire logic        misaligned_ref,
    input  wire logic        hw_error,
    input  wire logic        fp_error,
    input  wire logic        sup_write_ro_user,
    input  wire logic        write_through_req,
    input  wire logic        cache_hit,
    input  wire logic        unpaged_cycle,
    input  wire logic        page_uc,
    input  wire logic        page_wt,
    input  wire logic        desc_load,
    input  wire logic        desc_accessed,
    input  wire logic [3:0]  bp_addr_hit,
    input  wire logic [1:0]  acc_kind,
    // derived controls
    output logic             ext_phys_addr_en,
    output logic             tlb_flush_nonglobal,
    output logic             tlb_flush_global,
    output logic             counter_read_ok,
    output logic             timestamp_read_ok,
    output logic             virt_int_en,
    output logic             large_4m_ok,
    output logic             large_2m_ok,
    output logic             machine_check_exc,
    output logic             fp_native_report,
    output logic             fp_legacy_report,
    output logic             write_blocked,
    output logic             align_fault,
    output logic             write_through_issue,
    output logic             inval_cycle_en,
    output logic             cache_enable,
    output logic             cache_disable_pin,
    output logic             write_through_pin,
    output logic             locked_rmw_req,
    output logic [3:0]       bp_match,
    output logic             invalid_opcode_fault,
    output logic             os_simd_exception_support,
    output logic             os_state_save_support
);
    import crf_pkg::*;

    function automatic logic type_match(input logic [1:0] ty, input logic dx,
                                        input logic [1:0] kind);
        logic m;
        m = 1'b0;
        case (ty)
            2'h0: m = (kind == KIND_EXEC);
            2'h1: m = (kind == KIND_WRITE);
            // undefined encoding without debug extensions never matches
            2'h2: m = dx && (kind == KIND_IO);
            default: m = (kind == KIND_WRITE) || (kind == KIND_READ);
        endcase
        return m;
    endfunction : type_match

    logic [31:0] main_control_r;
    logic [31:0] page_base_control_r;
    logic [31:0] extension_control_r;
    logic [31:0] debug_status_r;
    logic [31:0] debug_control_r;
    logic        fault_sticky_r;
    logic        dp_valid_r;
    logic        dp_write_r;
    logic [7:0]  dp_addr_r;

    // address phase decode
    wire         ap_take  = hsel && htrans[1] && hready;
    wire  [7:0]  ap_addr  = haddr[7:0];
    wire         dx       = extension_control_r[DBG_EXT_BIT];
    wire         ap_alias = (ap_addr == ALIAS_LO_OFS) || (ap_addr == ALIAS_HI_OFS);
    wire         ap_stat  = (ap_addr == DSTAT_OFS) || (ap_addr == ALIAS_LO_OFS && !dx);
    wire         ap_ctrl  = (ap_addr == DCTRL_OFS) || (ap_addr == ALIAS_HI_OFS && !dx);
    logic [31:0] rd_data;
    always_comb begin
        if (ap_addr == MAIN_OFS) begin
            rd_data = main_control_r;
        end else if (ap_addr == PBASE_OFS) begin
            rd_data = page_base_control_r;
        end else if (ap_addr == EXT_OFS) begin
            rd_data = extension_control_r;
        end else if (ap_stat) begin
            rd_data = debug_status_r;
        end else if (ap_ctrl) begin
            rd_data = debug_control_r;
        end else if (ap_addr == FAULT_OFS) begin
            rd_data = {31'h0000_0000, fault_sticky_r};
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // data phase write decode
    wire wr_en    = dp_valid_r && dp_write_r;
    wire dp_dx_ok = !dx;
    wire wr_main  = wr_en && (dp_addr_r == MAIN_OFS);
    wire wr_pbase = wr_en && (dp_addr_r == PBASE_OFS);
    wire wr_ext   = wr_en && (dp_addr_r == EXT_OFS);
    // (RULE22) alias routing for writes
    wire wr_stat  = wr_en && ((dp_addr_r == DSTAT_OFS) ||
                              (dp_addr_r == ALIAS_LO_OFS && dp_dx_ok));
    wire wr_ctrl  = wr_en && ((dp_addr_r == DCTRL_OFS) ||
                              (dp_addr_r == ALIAS_HI_OFS && dp_dx_ok));
    wire wr_fault = wr_en && (dp_addr_r == FAULT_OFS) && hwdata[0];
    // (RULE22) alias reference with extensions on faults
    wire alias_fault = ap_take && ap_alias && dx;

    // breakpoint type decode per slot
    logic [3:0] bp_hit_now;
    genvar g;
    generate
        for (g = 0; g < NUM_BP; g++) begin : g_bp
            // (RULE20) type field decode
            assign bp_hit_now[g] = bp_addr_hit[g] &&
                type_match(debug_control_r[TYPE_LSB+4*g +: 2], dx, acc_kind);
        end
    endgenerate

    wire         pg   = main_control_r[PAGING_BIT];
    wire         xpa  = extension_control_r[XPA_BIT];
    wire         lpg  = extension_control_r[LPG_BIT];
    wire         base_chg = wr_pbase || task_switch;
    // (RULE19) bit 12 write ignored, hits set and win over write
    wire  [31:0] dstat_nxt = (wr_stat ? (hwdata & DSTAT_MASK) : debug_status_r) |
                             {28'h000_0000, bp_hit_now};
    // (RULE21) reserved debug control bits held at zero
    wire  [31:0] dctrl_nxt = wr_ctrl ? (hwdata & DCTRL_MASK) : debug_control_r;
    // fault sticky: a new fault wins over a clearing write
    wire         fault_nxt = alias_fault || (fault_sticky_r && !wr_fault);

    // bus tracking and register storage
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_valid_r          <= 1'b0;
            dp_write_r          <= 1'b0;
            dp_addr_r           <= 8'h00;
            hrdata              <= 32'h0000_0000;
            hreadyout           <= 1'b0;
            hresp               <= 1'b0;
            main_control_r      <= MAIN_RST;
            page_base_control_r <= PBASE_RST;
            // (RULE5) extension control clears at reset
            extension_control_r <= EXT_RST;
            debug_status_r      <= DSTAT_RST;
            debug_control_r     <= DCTRL_RST;
            fault_sticky_r      <= 1'b0;
        end else begin
            dp_valid_r <= ap_take;
            dp_write_r <= hwrite;
            dp_addr_r  <= ap_addr;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (ap_take && !hwrite) begin
                hrdata <= rd_data;
            end
            if (wr_main) begin
                main_control_r <= hwdata;
            end
            if (wr_pbase) begin
                page_base_control_r <= hwdata;
            end
            // (RULE1) capability bits stored for the core
            if (wr_ext) begin
                extension_control_r <= hwdata & EXT_MASK;
            end
            debug_status_r  <= dstat_nxt;
            debug_control_r <= dctrl_nxt;
            fault_sticky_r  <= fault_nxt;
        end
    end

    // derived control outputs, one cycle behind their causes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_phys_addr_en          <= 1'b0;
            tlb_flush_nonglobal       <= 1'b0;
            tlb_flush_global          <= 1'b0;
            counter_read_ok           <= 1'b0;
            timestamp_read_ok         <= 1'b0;
            virt_int_en               <= 1'b0;
            large_4m_ok               <= 1'b0;
            large_2m_ok               <= 1'b0;
            machine_check_exc         <= 1'b0;
            fp_native_report          <= 1'b0;
            fp_legacy_report          <= 1'b0;
            write_blocked             <= 1'b0;
            align_fault               <= 1'b0;
            write_through_issue       <= 1'b0;
            inval_cycle_en            <= 1'b0;
            cache_enable              <= 1'b0;
            cache_disable_pin         <= 1'b0;
            write_through_pin         <= 1'b0;
            locked_rmw_req            <= 1'b0;
            bp_match                  <= 4'h0;
            invalid_opcode_fault      <= 1'b0;
            os_simd_exception_support <= 1'b0;
            os_state_save_support     <= 1'b0;
        end else begin
            // (RULE2) (RULE17) extension only with paging on
            ext_phys_addr_en    <= xpa && pg;
            // (RULE3) global entries survive unless global pages off
            tlb_flush_nonglobal <= base_chg;
            tlb_flush_global    <= base_chg && !extension_control_r[GLB_BIT];
            // (RULE4) counter read privilege
            counter_read_ok     <= extension_control_r[CTR_BIT] || (cpl == CPL_KERNEL);
            // (RULE8) timestamp read privilege
            timestamp_read_ok   <= !extension_control_r[TS_RESTR_BIT] || (cpl == CPL_KERNEL);
            // (RULE6) (RULE7) virtual interrupt support by mode
            virt_int_en <= (v86_mode && extension_control_r[V86_EXT_BIT]) ||
                           (!v86_mode && main_control_r[PROT_EN_BIT] &&
                            extension_control_r[VIP_BIT]);
            // (RULE9) large page sizes
            large_4m_ok         <= lpg && pg && !xpa;
            large_2m_ok         <= lpg && pg && xpa;
            // (RULE10) machine check gating
            machine_check_exc   <= hw_error && extension_control_r[MCK_BIT];
            // (RULE11) float error route
            fp_native_report    <= fp_error && main_control_r[FE_BIT];
            fp_legacy_report    <= fp_error && !main_control_r[FE_BIT];
            // (RULE12) write protect
            write_blocked       <= sup_write_ro_user && main_control_r[WP_BIT];
            // (RULE13) alignment needs both flags
            align_fault <= misaligned_ref && alignment_check && main_control_r[MA_BIT];
            // (RULE14) hitting write-throughs suppressed under not-write-through
            write_through_issue <= write_through_req &&
                                   !(main_control_r[NT_BIT] && cache_hit);
            inval_cycle_en      <= !main_control_r[NT_BIT];
            // (RULE15) internal cache enable
            cache_enable        <= !main_control_r[CO_BIT];
            // (RULE16) unpaged cycles take the base register flags
            if (pg && unpaged_cycle) begin
                cache_disable_pin <= page_base_control_r[PNC_BIT];
                write_through_pin <= page_base_control_r[PTH_BIT];
            end else begin
                cache_disable_pin <= page_uc;
                write_through_pin <= page_wt;
            end
            // (RULE18) locked update only when not yet accessed
            locked_rmw_req            <= desc_load && !desc_accessed;
            bp_match                  <= bp_hit_now;
            invalid_opcode_fault      <= alias_fault;
            os_simd_exception_support <= extension_control_r[OS_SIMD_BIT];
            os_state_save_support     <= extension_control_r[OS_SAVE_BIT];
        end
    end

    // checks
    a_ext_reset_zero: assert property ( // (RULE5)
        @(posedge core_clk) $rose(reset_n) |-> extension_control_r == 32'h0000_0000)
        else $error("extension control not zero after reset");

    a_xpa_needs_pg: assert property ( // (RULE17)
        @(posedge core_clk) disable iff (!reset_n)
        ##1 ext_phys_addr_en |-> $past(pg) && $past(xpa))
        else $error("address extension without paging");

    a_global_kept: assert property ( // (RULE3)
        @(posedge core_clk) disable iff (!reset_n)
        (task_switch && extension_control_r[GLB_BIT]) |=> tlb_flush_nonglobal && !tlb_flush_global)
        else $error("global entries flushed with global pages on");

    a_counter_priv: assert property ( // (RULE4)
        @(posedge core_clk) disable iff (!reset_n)
        (!extension_control_r[CTR_BIT] && cpl != CPL_KERNEL) |=> !counter_read_ok)
        else $error("counter read allowed outside kernel");

    a_ts_priv: assert property ( // (RULE8)
        @(posedge core_clk) disable iff (!reset_n)
        (extension_control_r[TS_RESTR_BIT] && cpl == 2'h3) |=> !timestamp_read_ok)
        else $error("timestamp read allowed in user mode");

    a_dstat_bit12: assert property ( // (RULE19)
        @(posedge core_clk) disable iff (!reset_n)
        wr_stat && hwdata[12] |=> !debug_status_r[12])
        else $error("debug status bit 12 became set");

    a_dctrl_resv: assert property ( // (RULE21)
        @(posedge core_clk) disable iff (!reset_n)
        wr_ctrl |=> debug_control_r[15:14] == 2'h0 && debug_control_r[12:11] == 2'h0)
        else $error("reserved debug control bits set");

    a_alias_fault: assert property ( // (RULE22)
        @(posedge core_clk) disable iff (!reset_n)
        (ap_take && ap_alias && dx) |=> invalid_opcode_fault ##1 fault_sticky_r)
        else $error("alias reference did not fault");

    a_io_undef: assert property ( // (RULE20)
        @(posedge core_clk) disable iff (!reset_n)
        (!dx && acc_kind == KIND_IO) |=> bp_match == 4'h0)
        else $error("io breakpoint matched without extensions");

    a_mce_gate: assert property ( // (RULE10)
        @(posedge core_clk) disable iff (!reset_n)
        machine_check_exc |-> $past(extension_control_r[MCK_BIT]) && $past(hw_error))
        else $error("machine check raised while disabled");

    a_align_both: assert property ( // (RULE13)
        @(posedge core_clk) disable iff (!reset_n)
        (misaligned_ref && alignment_check && main_control_r[MA_BIT]) |=> align_fault)
        else $error("alignment fault missed");

    a_nt_suppress: assert property ( // (RULE14)
        @(posedge core_clk) disable iff (!reset_n)
        (main_control_r[NT_BIT] && cache_hit) |=> !write_through_issue && !inval_cycle_en)
        else $error("write-through not suppressed");

    a_pin_unpaged: assert property ( // (RULE16)
        @(posedge core_clk) disable iff (!reset_n)
        (pg && unpaged_cycle && !wr_pbase) |=>
            cache_disable_pin == page_base_control_r[PNC_BIT])
        else $error("cache pin not from base register");

    a_locked_rmw: assert property ( // (RULE18)
        @(posedge core_clk) disable iff (!reset_n)
        (desc_load && desc_accessed) |=> !locked_rmw_req)
        else $error("locked update on accessed descriptor");

    a_cache_off: assert property ( // (RULE15)
        @(posedge core_clk) disable iff (!reset_n)
        main_control_r[CO_BIT] |=> !cache_enable)
        else $error("cache left on while disabled");

    a_wp_block: assert property ( // (RULE12)
        @(posedge core_clk) disable iff (!reset_n)
        (sup_write_ro_user && main_control_r[WP_BIT]) |=> write_blocked)
        else $error("protected write not blocked");

    a_fp_native: assert property ( // (RULE11)
        @(posedge core_clk) disable iff (!reset_n)
        (fp_error && main_control_r[FE_BIT]) |=> fp_native_report && !fp_legacy_report)
        else $error("numeric error not reported natively");
endmodule : crf_bank

/* File: verif/crf_ext_cache.sv */
// external cache model fed by the bank's page attribute pins
`timescale 1ns/1ps
module crf_ext_cache (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // cache control pins from the bank
    input  wire logic cache_disable_pin,
    input  wire logic write_through_pin,
    // attributes of the current paged cycle
    output logic      page_uc,
    output logic      page_wt
);
    logic [7:0] lfsr_r;
    logic [7:0] lfsr_nxt;
    int         uncached_r;
    int         wthru_r;
    assign lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    // attributes are pseudo-random single bits each cycle, so a stale value matches by chance about half the time
    assign page_uc = lfsr_r[0];
    assign page_wt = lfsr_r[3];
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_r     <= 8'hA5;
            uncached_r <= 0;
            wthru_r    <= 0;
        end else begin
            lfsr_r     <= lfsr_nxt;
            uncached_r <= uncached_r + int'(cache_disable_pin);
            wthru_r    <= wthru_r + int'(write_through_pin);
        end
    end
endmodule : crf_ext_cache

/* File: verif/tb.sv */
// self-checking bench for the control register bank
`timescale 1ns/1ps
module tb;
    import crf_pkg::*;
    logic        core_clk, reset_n, hsel, hwrite, hreadyout, hresp, uc, wt;
    logic [31:0] haddr, hwdata, hrdata, rd, m_main, m_ext, m_pbase, m_dctrl;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [19:0] core_in;
    logic [25:0] seen;
    logic [7:0]  ofs [5];
    int          bad_count, n_tests, iof_n;
    int          seed = 32'h5D04;
    crf_bank u_crf_bank (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpl(core_in[19:18]), .v86_mode(core_in[17]),
        .task_switch(core_in[16]), .alignment_check(core_in[15]), .misaligned_ref(core_in[14]),
        .hw_error(core_in[13]), .fp_error(core_in[12]), .sup_write_ro_user(core_in[11]),
        .write_through_req(core_in[10]), .cache_hit(core_in[9]), .unpaged_cycle(core_in[8]),
        .page_uc(uc), .page_wt(wt), .desc_load(core_in[7]), .desc_accessed(core_in[6]),
        .bp_addr_hit(core_in[5:2]), .acc_kind(core_in[1:0]), .ext_phys_addr_en(seen[25]),
        .tlb_flush_nonglobal(seen[24]), .tlb_flush_global(seen[23]), .counter_read_ok(seen[22]),
        .timestamp_read_ok(seen[21]), .virt_int_en(seen[20]), .large_4m_ok(seen[19]),
        .large_2m_ok(seen[18]), .machine_check_exc(seen[17]), .fp_native_report(seen[16]),
        .fp_legacy_report(seen[15]), .write_blocked(seen[14]), .align_fault(seen[13]),
        .write_through_issue(seen[12]), .inval_cycle_en(seen[11]), .cache_enable(seen[10]),
        .cache_disable_pin(seen[9]), .write_through_pin(seen[8]), .locked_rmw_req(seen[7]),
        .bp_match(seen[6:3]), .invalid_opcode_fault(seen[2]),
        .os_simd_exception_support(seen[1]), .os_state_save_support(seen[0]));
    crf_ext_cache u_crf_ext_cache (.core_clk(core_clk), .reset_n(reset_n),
        .cache_disable_pin(seen[9]), .write_through_pin(seen[8]), .page_uc(uc), .page_wt(wt));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (seen[2] === 1'b1) iof_n <= iof_n + 1;
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        check("bus response", 32'(hresp), 32'h0);
        hsel <= 1'b0;
    endtask : bus
    function automatic logic [25:0] model(input logic [19:0] c, input logic [1:0] pp);
        logic       pg;
        logic       unp;
        logic [3:0] bm;
        logic [1:0] t;
        pg  = m_main[PAGING_BIT];
        unp = pg & c[8];
        for (int n = 0; n < NUM_BP; n++) begin
            t = m_dctrl[TYPE_LSB + 4 * n +: 2];
            bm[n] = c[2 + n] & ((t == 2'h0 && c[1:0] == KIND_EXEC)
                || (t == 2'h1 && c[1:0] == KIND_WRITE)
                || (t == 2'h2 && m_ext[DBG_EXT_BIT] && c[1:0] == KIND_IO)
                || (t == 2'h3 && (c[1:0] == KIND_READ || c[1:0] == KIND_WRITE)));
        end
        return {m_ext[XPA_BIT] & pg, c[16], c[16] & !m_ext[GLB_BIT],
            m_ext[CTR_BIT] | (c[19:18] == CPL_KERNEL), !m_ext[TS_RESTR_BIT] | (c[19:18] == 2'h0),
            (c[17] & m_ext[V86_EXT_BIT]) | (!c[17] & m_main[PROT_EN_BIT] & m_ext[VIP_BIT]),
            m_ext[LPG_BIT] & pg & !m_ext[XPA_BIT], m_ext[LPG_BIT] & pg & m_ext[XPA_BIT],
            c[13] & m_ext[MCK_BIT], c[12] & m_main[FE_BIT], c[12] & !m_main[FE_BIT],
            c[11] & m_main[WP_BIT], c[14] & c[15] & m_main[MA_BIT],
            c[10] & !(m_main[NT_BIT] & c[9]), !m_main[NT_BIT], !m_main[CO_BIT],
            unp ? m_pbase[PNC_BIT] : pp[1], unp ? m_pbase[PTH_BIT] : pp[0], c[7] & !c[6],
            bm, 1'b0, m_ext[OS_SIMD_BIT], m_ext[OS_SAVE_BIT]};
    endfunction : model
    // random core activity, each output compared one edge after its cause
    task automatic burst(input int n);
        logic [1:0]  pp;
        logic [25:0] e;
        repeat (n) begin
            @(posedge core_clk);
            core_in <= 20'($random(seed));
            @(posedge core_clk);
            pp = {uc, wt};
            #1;
            e = model(core_in, pp);
            check("paging ctl", 32'(seen[25:18]), 32'(e[25:18]));
            check("core ctl", 32'(seen[17:7]), 32'(e[17:7]));
            check("mode ctl", 32'(seen[20]), 32'(e[20]));
            check("debug ctl", 32'(seen[6:0]), 32'(e[6:0]));
        end
    endtask : burst
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (30000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        {reset_n, hsel, hwrite, htrans, haddr, hwdata, core_in} = '0;
        {m_main, m_ext, m_pbase, m_dctrl} = '0;
        hsize = 3'h2;
        ofs = '{MAIN_OFS, PBASE_OFS, EXT_OFS, DSTAT_OFS, DCTRL_OFS};
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            check("reset value", rd, 32'h0);
        end
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        burst(20);
        $display("test reset done");
        for (int r = 0; r < 10; r++) begin
            bus(1'b1, MAIN_OFS, 32'($random(seed)));
            m_main = hwdata;
            bus(1'b1, PBASE_OFS, 32'($random(seed)));
            m_pbase = hwdata;
            // random extension value, simd bit set at random and not tied to exception handling
            bus(1'b1, EXT_OFS, 32'($random(seed)));
            m_ext = hwdata & EXT_MASK;
            bus(1'b1, DCTRL_OFS, 32'($random(seed)));
            m_dctrl = hwdata & DCTRL_MASK;
            bus(1'b0, EXT_OFS, 32'h0);
            check("ext readback", rd, m_ext);
            bus(1'b0, DCTRL_OFS, 32'h0);
            check("dctrl readback", rd, m_dctrl);
            burst(40);
        end
        $display("test derived done");
        core_in <= '0;
        bus(1'b1, EXT_OFS, 32'h0);
        bus(1'b1, ALIAS_LO_OFS, 32'hFFFF_FFFF);
        bus(1'b0, DSTAT_OFS, 32'h0);
        check("status via alias", rd, DSTAT_MASK);
        bus(1'b1, ALIAS_HI_OFS, 32'hFFFF_FFFF);
        bus(1'b0, ALIAS_HI_OFS, 32'h0);
        check("control via alias", rd, DCTRL_MASK);
        bus(1'b1, EXT_OFS, 32'h1 << DBG_EXT_BIT);
        iof_n = 0;
        bus(1'b0, ALIAS_LO_OFS, 32'h0);
        repeat (3) @(posedge core_clk);
        check("alias faults", 32'(iof_n), 32'h1);
        bus(1'b0, FAULT_OFS, 32'h0);
        check("fault flag", rd, 32'h1);
        bus(1'b1, FAULT_OFS, 32'h1);
        bus(1'b0, FAULT_OFS, 32'h0);
        check("fault clear", rd, 32'h0);
        $display("test alias done");
        give_verdict();
    end
endmodule : tb
